// >>> verif/reader_timer_bench.sv
// self-checking bench for the first reader timer
`timescale 1ns/1ps
module reader_timer_bench;
	import timer_pkg::*;
	logic clk_sys = 0;
	logic rst_n = 0;
	apb_req_t apb_req = '0;
	link_events_t events = '0;
	logic [2:0] other_timer_halted = '0;
	logic slow_oscillator = 0;
	logic pready, pslverr, first_timer_active, first_timer_underflow, irq;
	logic [31:0] prdata, rdata;
	logic [2:0] other_timer_active;
	logic err;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	reader_timer reader_timer_i (.clk_sys, .rst_n, .apb_req, .pready,
		.pslverr, .prdata, .events, .other_timer_halted, .slow_oscillator,
		.other_timer_active, .first_timer_active, .first_timer_underflow,
		.irq);
	always #2 clk_sys = ~clk_sys;
	// guard against a hung handshake; the underflow wait stops itself after 400 cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [7:0] d);
		@(posedge clk_sys);
		apb_req <= '{1'b1, 1'b0, w, {idx[5:0], 2'b00}, {24'h0, d}};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		apb_req <= '0;
		// one more edge so the write has landed before any check
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(rdata, {24'h0, exp});
	endtask
	task automatic pulse(input link_events_t v);
		@(posedge clk_sys);
		events <= v;
		@(posedge clk_sys);
		events <= '0;
		@(posedge clk_sys);
	endtask
	task automatic t_reset;
		rd(8'h0e, 8'h00);
		rd(8'h13, 8'h00);
		xfer(1'b1, 8'h0f, 8'hff);
		rd(8'h0f, 8'hbb);
		xfer(1'b1, 8'h0f, 8'h00);
	endtask
	task automatic t_underflow;
		int n;
		n = 0;
		xfer(1'b1, 8'h10, 8'h00);
		xfer(1'b1, 8'h11, 8'h02);
		xfer(1'b1, 8'h21, 8'h01);
		xfer(1'b1, 8'h0e, 8'h11);
		chk(first_timer_active, 1);
		while (first_timer_underflow !== 1'b1 && n < 400)
		begin
			@(posedge clk_sys);
			n++;
		end
		chk(first_timer_underflow, 1);
		repeat (3) @(posedge clk_sys);
		chk(first_timer_active, 0);
		chk(irq, 1);
		rd(8'h20, 8'h01);
		rd(8'h12, 8'h00);
		xfer(1'b1, 8'h21, 8'h00);
		@(posedge clk_sys);
		chk(irq, 0);
		xfer(1'b1, 8'h21, 8'h01);
		xfer(1'b1, 8'h20, 8'h01);
		@(posedge clk_sys);
		chk(irq, 0);
	endtask
	task automatic t_masked;
		xfer(1'b1, 8'h0e, 8'hf0);
		rd(8'h0e, 8'h00);
		xfer(1'b1, 8'h0e, 8'he2);
		rd(8'h0e, 8'h20);
		chk(other_timer_active, 3'b001);
		other_timer_halted <= 3'b001;
		@(posedge clk_sys);
		other_timer_halted <= 3'b000;
		@(posedge clk_sys);
		chk(other_timer_active, 3'b000);
	endtask
	task automatic t_reload;
		xfer(1'b1, 8'h11, 8'h03);
		xfer(1'b1, 8'h0f, 8'h02);
		xfer(1'b1, 8'h0e, 8'h11);
		pulse(4'b0001);
		xfer(1'b1, 8'h11, 8'h09);
		pulse(4'b0001);
		rd(8'h13, 8'h01);
		xfer(1'b1, 8'h0e, 8'h11);
		rd(8'h13, 8'h09);
		xfer(1'b1, 8'h0f, 8'h03);
		pulse(4'b0010);
		rd(8'h13, 8'h08);
		xfer(1'b1, 8'h0e, 8'h01);
	endtask
	task automatic t_rx;
		xfer(1'b1, 8'h10, 8'hff);
		xfer(1'b1, 8'h0f, 8'ha0);
		xfer(1'b1, 8'h0e, 8'h11);
		pulse(4'b0100);
		chk(first_timer_active, 1);
		xfer(1'b1, 8'h0f, 8'h80);
		pulse(4'b0100);
		chk(first_timer_active, 0);
		rd(8'h20, 8'h02);
		xfer(1'b1, 8'h20, 8'h02);
	endtask
	task automatic t_auto;
		xfer(1'b1, 8'h0f, 8'h00);
		pulse(4'b1000);
		chk(first_timer_active, 0);
		xfer(1'b1, 8'h0f, 8'h10);
		pulse(4'b1000);
		chk(first_timer_active, 1);
		xfer(1'b1, 8'h0e, 8'h01);
		chk(first_timer_active, 0);
	endtask
	task automatic t_unmapped;
		xfer(1'b1, 8'h15, 8'hff);
		chk(err, 1);
		xfer(1'b0, 8'h15, 8'h00);
		chk(rdata, 32'h0);
	endtask
	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_underflow();
		t_masked();
		t_reload();
		t_rx();
		t_auto();
		t_unmapped();
		print_verdict();
	end
endmodule

// >>> verif/reader_timer_checker.sv
// port assertions for the first reader timer
`timescale 1ns/1ps
module reader_timer_checker
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire timer_pkg::apb_req_t apb_req,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire timer_pkg::link_events_t events,
	input wire logic [2:0] other_timer_halted,
	input wire logic slow_oscillator,
	input wire logic [2:0] other_timer_active,
	input wire logic first_timer_active,
	input wire logic first_timer_underflow,
	input wire logic irq
);
	import timer_pkg::*;
	logic acc;
	logic rd_acc;
	logic wr_run;
	assign acc = apb_req.psel & apb_req.penable;
	assign rd_acc = acc & !apb_req.pwrite;
	assign wr_run = acc & apb_req.pwrite & (apb_req.paddr == 8'h38);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_first_run_set: assert property (wr_run && apb_req.pwdata[0] &&
		apb_req.pwdata[4] |=> first_timer_active) else $error("no start");
	a_first_run_clr: assert property (wr_run && apb_req.pwdata[0] &&
		!apb_req.pwdata[4] |=> !first_timer_active) else $error("no stop");
	a_second_write: assert property (wr_run && apb_req.pwdata[1] |=>
		other_timer_active[0] == $past(apb_req.pwdata[5]))
		else $error("strobed bit wrong");
	a_keep_unstrobed: assert property (wr_run && !apb_req.pwdata[1] &&
		!other_timer_halted[0] |=> $stable(other_timer_active[0]))
		else $error("unstrobed bit changed");
	a_halt_clears: assert property (other_timer_halted[0] &&
		!(wr_run && apb_req.pwdata[1]) |=> !other_timer_active[0])
		else $error("halt ignored");
	a_read_nibble: assert property (rd_acc && apb_req.paddr == 8'h38
		|-> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0)
		else $error("strobe bits read back");
	a_read_idle: assert property (!rd_acc |-> prdata == 32'h0)
		else $error("read data outside access");
	a_start_cause: assert property ($rose(first_timer_active) |->
		$past(wr_run && apb_req.pwdata[0]) || $past(events.tx_end) ||
		$past(slow_oscillator, 2) || $past(slow_oscillator, 3) ||
		$past(slow_oscillator, 4)) else $error("start without cause");
	a_uflow_running: assert property (first_timer_underflow |->
		$past(first_timer_active) || $past(first_timer_active, 2))
		else $error("underflow while idle");
	c_underflow: cover property (first_timer_underflow);
	c_irq: cover property (irq);
	c_second_run: cover property ($rose(other_timer_active[0]));
endmodule

bind reader_timer reader_timer_checker reader_timer_checker_i (.clk_sys,
	.rst_n, .apb_req, .pready, .pslverr, .prdata, .events,
	.other_timer_halted, .slow_oscillator, .other_timer_active,
	.first_timer_active, .first_timer_underflow, .irq);

// >>> verilog/reader_timer.sv
// first reader timer with shared run control, behind an apb slave
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "timer_defines.svh"

module reader_timer
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire timer_pkg::apb_req_t apb_req,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire timer_pkg::link_events_t events,
	input wire logic [2:0] other_timer_halted,
	input wire logic slow_oscillator,
	output logic [2:0] other_timer_active,
	output logic first_timer_active,
	output logic first_timer_underflow,
	output logic irq
);
	import timer_pkg::*;

	logic [`REG_W-1:0] index;
	logic mapped;
	logic wr_en;
	logic rd_en;
	logic [`NUM_TIMERS-1:0] active_q;
	logic [`NUM_TIMERS-1:0] active_d;
	zero_config_t config_q;
	logic [`REG_W-1:0] reload_high_q;
	logic [`REG_W-1:0] reload_low_q;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [`IRQ_BITS-1:0] irq_status_q;
	logic [`IRQ_BITS-1:0] irq_mask_q;
	logic [`IRQ_BITS-1:0] irq_event;
	logic [`ACC_W-1:0] acc_q;
	logic carrier_tick;
	logic [`SLOW_DIV_W-1:0] div_q;
	logic slow_tick;
	logic tick;
	logic osc_meta_q;
	logic osc_sync_q;
	logic osc_prev_q;
	logic osc_rise;
	logic trim_mode;
	logic wrap_allowed;
	logic start_evt;
	logic stop_evt;
	logic underflow;
	logic rx_halt;
	logic write_run;
	logic [`REG_W-1:0] wbyte;
	logic [`REG_W-1:0] rdata_d;
	logic [31:0] prdata_q;

	// register index from an aligned word address
	function automatic logic [`REG_W-1:0] word_index(
		input logic [`ADDR_W-1:0] addr);
		word_index = {{`ADDR_LSB{1'b0}}, addr[`ADDR_W-1:`ADDR_LSB]};
	endfunction

	// strobed bits take the written value, others keep theirs
	function automatic logic [`NUM_TIMERS-1:0] masked_update(
		input logic [`NUM_TIMERS-1:0] cur,
		input logic [`REG_W-1:0] wdata);
		logic [`NUM_TIMERS-1:0] strobe;
		logic [`NUM_TIMERS-1:0] value;
		strobe = wdata[`NUM_TIMERS-1:0];
		value = wdata[`REG_W-1:`RUN_ACTIVE_LSB];
		masked_update = (cur & ~strobe) | (value & strobe);
	endfunction

	assign index = word_index(apb_req.paddr);
	assign wbyte = apb_req.pwdata[`REG_W-1:0];

	always_comb
	begin
		case (index)
			`IDX_RUN_CONTROL, `IDX_ZERO_CONFIG, `IDX_RELOAD_HIGH,
			`IDX_RELOAD_LOW, `IDX_COUNT_HIGH, `IDX_COUNT_LOW,
			`IDX_IRQ_STATUS, `IDX_IRQ_MASK:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	end

	// zero wait state slave; misaligned or unknown addresses error
	assign pready = 1'b1;
	assign pslverr = apb_req.psel & apb_req.penable &
		(~mapped | (apb_req.paddr[`ADDR_LSB-1:0] != 2'b00));
	assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite &
		~pslverr;
	assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite &
		~pslverr;
	assign write_run = wr_en && index == `IDX_RUN_CONTROL;

	// 13.56 MHz enable by fractional accumulation of the system clock
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			acc_q <= '0;
		else if (acc_q >= `ACC_W'(`SYS_CLK_KHZ - `CARRIER_KHZ))
			acc_q <= acc_q - `ACC_W'(`SYS_CLK_KHZ - `CARRIER_KHZ);
		else
			acc_q <= acc_q + `ACC_W'(`CARRIER_KHZ);
	end
	assign carrier_tick = acc_q >= `ACC_W'(`SYS_CLK_KHZ - `CARRIER_KHZ);

	// 211.875 kHz is the carrier divided by 64
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			div_q <= '0;
		else if (carrier_tick)
			div_q <= div_q + `SLOW_DIV_W'(1);
	end
	assign slow_tick = carrier_tick &&
		div_q == `SLOW_DIV_W'(`SLOW_DIV - 1);

	always_comb
	begin
		case (config_q.tick_source_select)
			SRC_CARRIER: tick = carrier_tick; // RL10
			SRC_CARRIER_DIV: tick = slow_tick; // RL10
			SRC_THIRD_UNDERFLOW: tick = events.third_underflow; // RL11
			SRC_SECOND_UNDERFLOW: tick = events.second_underflow; // RL11
			default: tick = 1'b0;
		endcase
	end

	// oscillator pin is asynchronous: two stages before edge detect
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_meta_q <= 1'b0;
			osc_sync_q <= 1'b0;
			osc_prev_q <= 1'b0;
		end
		else
		begin
			osc_meta_q <= slow_oscillator;
			osc_sync_q <= osc_meta_q;
			osc_prev_q <= osc_sync_q;
		end
	end
	assign osc_rise = osc_sync_q & ~osc_prev_q;

	assign trim_mode = config_q.auto_start_mode == START_TRIM ||
		config_q.auto_start_mode == START_TRIM_WRAP; // RL7
	// trimming without underflow parks at zero instead of wrapping
	assign wrap_allowed = config_q.auto_start_mode != START_TRIM; // RL7

	assign underflow = active_q[0] && tick && count_q == 16'h0000 &&
		wrap_allowed; // RL9
	assign rx_halt = events.rx_four_bits && config_q.halt_on_receive &&
		!trim_mode && active_q[0]; // RL4 RL5

	// hardware start and stop requests for the first timer
	always_comb
	begin
		start_evt = 1'b0;
		stop_evt = 1'b0;
		case (config_q.auto_start_mode)
			START_MANUAL:
				start_evt = 1'b0; // RL6
			START_TX_END:
				start_evt = events.tx_end && !active_q[0]; // RL6
			START_TRIM, START_TRIM_WRAP:
			begin
				start_evt = osc_rise && !active_q[0]; // RL7
				stop_evt = osc_rise && active_q[0]; // RL7
			end
			default:
				start_evt = 1'b0;
		endcase
		if (rx_halt)
			stop_evt = 1'b1; // RL4
		if (underflow && !config_q.reload_on_zero)
			stop_evt = 1'b1; // RL8
	end

	// software strobes win over hardware events in the same cycle
	always_comb
	begin
		active_d = active_q;
		active_d[`NUM_TIMERS-1:1] = active_q[`NUM_TIMERS-1:1] &
			~other_timer_halted;
		if (start_evt)
			active_d[0] = 1'b1;
		else if (stop_evt)
			active_d[0] = 1'b0;
		if (write_run)
			active_d = masked_update(active_d, wbyte); // RL1 RL3
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			active_q <= '0;
		else
			active_q <= active_d; // RL2
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			config_q <= zero_config_t'(`RESET_BYTE);
			reload_high_q <= `RESET_BYTE;
			reload_low_q <= `RESET_BYTE;
		end
		else if (wr_en)
		begin
			case (index)
				`IDX_ZERO_CONFIG:
					config_q <= zero_config_t'(wbyte & `CFG_VALID_MASK); // RL17
				`IDX_RELOAD_HIGH:
					reload_high_q <= wbyte; // RL13
				`IDX_RELOAD_LOW:
					reload_low_q <= wbyte; // RL13
				default:
					reload_low_q <= reload_low_q;
			endcase
		end
	end

	// counter: reload on a start or on underflow with reload on zero, never on a reload write
	always_comb
	begin
		count_d = count_q;
		if ((write_run && wbyte[0] && wbyte[`RUN_ACTIVE_LSB]) ||
			start_evt)
			count_d = {reload_high_q, reload_low_q}; // RL3 RL12
		else if (active_q[0] && tick && !rx_halt)
		begin
			if (count_q != 16'h0000)
				count_d = count_q - 16'h0001; // RL16
			else if (underflow && config_q.reload_on_zero)
				count_d = {reload_high_q, reload_low_q}; // RL8
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			count_q <= `RESET_COUNT;
		else
			count_q <= count_d;
	end

	assign irq_event[`IRQ_UNDERFLOW] = underflow; // RL9
	assign irq_event[`IRQ_RX_HALT] = rx_halt;

	// sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irq_status_q <= '0;
		else if (wr_en && index == `IDX_IRQ_STATUS)
			irq_status_q <= (irq_status_q & ~wbyte[`IRQ_BITS-1:0]) |
				irq_event;
		else
			irq_status_q <= irq_status_q | irq_event;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irq_mask_q <= '0;
		else if (wr_en && index == `IDX_IRQ_MASK)
			irq_mask_q <= wbyte[`IRQ_BITS-1:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(irq_status_q & irq_mask_q);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			first_timer_underflow <= 1'b0;
		else
			first_timer_underflow <= underflow;
	end

	always_comb
	begin
		case (index)
			`IDX_RUN_CONTROL:
				rdata_d = {active_q, {`NUM_TIMERS{1'b0}}}; // RL2 RL17
			`IDX_ZERO_CONFIG:
				rdata_d = config_q;
			`IDX_RELOAD_HIGH:
				rdata_d = reload_high_q;
			`IDX_RELOAD_LOW:
				rdata_d = reload_low_q;
			`IDX_COUNT_HIGH:
				rdata_d = count_q[15:8];
			`IDX_COUNT_LOW:
				rdata_d = count_q[7:0]; // RL15
			`IDX_IRQ_STATUS:
				rdata_d = {{(`REG_W-`IRQ_BITS){1'b0}}, irq_status_q};
			`IDX_IRQ_MASK:
				rdata_d = {{(`REG_W-`IRQ_BITS){1'b0}}, irq_mask_q};
			default:
				rdata_d = `RESET_BYTE;
		endcase
	end

	// read data captured at setup so it is a flop in the access phase
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			prdata_q <= '0;
		else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
			prdata_q <= {{(`DATA_W-`REG_W){1'b0}}, rdata_d};
	end
	assign prdata = rd_en ? prdata_q : '0;

	assign first_timer_active = active_q[0];
	assign other_timer_active = active_q[`NUM_TIMERS-1:1];

endmodule

// >>> verilog/timer_defines.svh
// register map, field positions and timing constants of the timer block
// Notes on behaviour
// RL1: masked write updates only strobed running bits
// RL2: bits 7..4 show timers four..one counting
// RL3: setting running starts, clearing stops timer
// RL4: halt on receive stops after four bits
// RL5: trimming modes ignore halt on receive
// RL6: mode 00 manual, 01 starts after transmit
// RL7: modes 10/11 trimming, rising edge start/stop
// RL8: reload on zero restarts, else stops
// RL9: underflow sets interrupt request flag
// RL10: source 00 13.56 MHz, 01 211.875 kHz
// RL11: source 10 third, 11 second underflow
// RL12: every start loads sixteen bit reload
// RL13: reload writes wait for next start
// RL14: software avoids count reads during reception
// RL15: count low byte readable at 13h
// RL16: counter decrements one per selected tick
// RL17: strobes and reserved bits read zero
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

`define ADDR_W 8
`define DATA_W 32
`define REG_W 8
// register indices; byte address is four times the index
`define IDX_RUN_CONTROL 8'h0e
`define IDX_ZERO_CONFIG 8'h0f
`define IDX_RELOAD_HIGH 8'h10
`define IDX_RELOAD_LOW 8'h11
`define IDX_COUNT_HIGH 8'h12
`define IDX_COUNT_LOW 8'h13
`define IDX_IRQ_STATUS 8'h20
`define IDX_IRQ_MASK 8'h21
`define ADDR_LSB 2
// field positions
`define RUN_ACTIVE_LSB 4
`define NUM_TIMERS 4
`define CFG_VALID_MASK 8'hbb
`define IRQ_BITS 2
`define IRQ_UNDERFLOW 0
`define IRQ_RX_HALT 1
`define RESET_BYTE 8'h00
`define RESET_COUNT 16'h0000
// timing: tick rates in kHz, derived by phase accumulator
`define SYS_CLK_KHZ 250000
`define CARRIER_KHZ 13560
`define ACC_W 18
`define SLOW_DIV 64
`define SLOW_DIV_W 6

`endif

// >>> verilog/timer_pkg.sv
// types shared by the timer block
package timer_pkg;

	typedef enum logic [1:0] {
		START_MANUAL,
		START_TX_END,
		START_TRIM,
		START_TRIM_WRAP
	} start_mode_t;

	typedef enum logic [1:0] {
		SRC_CARRIER,
		SRC_CARRIER_DIV,
		SRC_THIRD_UNDERFLOW,
		SRC_SECOND_UNDERFLOW
	} tick_src_t;

	typedef struct packed {
		logic halt_on_receive;
		logic rsv6;
		start_mode_t auto_start_mode;
		logic reload_on_zero;
		logic rsv2;
		tick_src_t tick_source_select;
	} zero_config_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic tx_end;
		logic rx_four_bits;
		logic second_underflow;
		logic third_underflow;
	} link_events_t;

endpackage
